// file: src/wlm_write_leveling.sv
`timescale 1ns/100ps
// write leveling mode of the memory device, with an apb register view
module wlm_write_leveling #(
	parameter int LANES = 2
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               arst_n,
	// apb slave
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// command and clock pins
	input  wire logic               ck_pin,
	input  wire logic               termination_control_pin,
	input  wire logic               cs_n_pin,
	input  wire logic               ms_n_pin,
	input  wire logic [2:0]         mr_sel_pin,
	input  wire logic               output_disable_bit,
	input  wire logic               leveling_enable_bit,
	// strobe pins, one per byte lane
	input  wire logic [LANES-1:0]   dqs_pin,
	// data pins
	output logic [LANES*8-1:0]      dq_o,
	output logic [LANES*8-1:0]      dq_oe,
	output logic [LANES-1:0]        dqs_oe,
	// termination controls
	output logic                    dqs_term_en,
	output logic                    dqs_term_nom,
	output logic                    dq_term_en,
	output logic                    wl_active
);

	logic [wlm_pkg::WLM_PIN_W-1:0]  pin_raw;
	logic [wlm_pkg::WLM_PIN_W-1:0]  pin_s1_r;
	logic [wlm_pkg::WLM_PIN_W-1:0]  pin_s2_r;
	logic [wlm_pkg::WLM_PIN_W-1:0]  pin_s3_r;
	logic [wlm_pkg::WLM_PIN_W-1:0]  pin_r;
	logic                           cs_prev_r;
	logic                           cmd_take;
	logic                           cmd_ms;
	logic                           cmd_lvl_reg;
	logic                           term_ok;
	logic                           term_eff;
	wlm_pkg::wlm_state_t            state_r;
	logic [7:0]                     cnt_r;
	logic [7:0]                     gap_r;
	logic                           qoff_r;
	logic [2:0]                     ctrl_r;
	logic [1:0]                     err_r;
	logic [1:0]                     err_set;
	logic [7:0]                     mod_cyc_r;
	logic [7:0]                     gap_cyc_r;
	logic                           wr_en;
	logic [LANES-1:0]               lane_fb;
	logic [LANES-1:0]               lane_on;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// pack the pins so one three-stage filter serves all of them
	assign pin_raw = {ck_pin, termination_control_pin, cs_n_pin, ms_n_pin,
	                  mr_sel_pin, output_disable_bit, leveling_enable_bit};

	// a bit moves only when stages two and three agree
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_s1_r <= wlm_pkg::WLM_PIN_RST;
			pin_s2_r <= wlm_pkg::WLM_PIN_RST;
			pin_s3_r <= wlm_pkg::WLM_PIN_RST;
			pin_r    <= wlm_pkg::WLM_PIN_RST;
		end
		else
		begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
		end
	end

	// previous select level for command edge detection
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			cs_prev_r <= 1'b1;
		else
			cs_prev_r <= pin_r[wlm_pkg::WLM_PIN_CS_N];
	end

	// a command is taken on the falling edge of the filtered select
	assign cmd_take = cs_prev_r && !pin_r[wlm_pkg::WLM_PIN_CS_N];
	assign cmd_ms      = cmd_take && !pin_r[wlm_pkg::WLM_PIN_MS_N];
	assign cmd_lvl_reg = cmd_ms &&
	                     (pin_r[wlm_pkg::WLM_PIN_SEL +: 3] == wlm_pkg::WLM_MR_LEVEL);

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	// entry, leveling, exit; the timer measures the mode update delay
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= wlm_pkg::WLM_NORMAL;
			cnt_r   <= 8'h00;
		end
		else
		begin
			case (state_r)
				wlm_pkg::WLM_NORMAL:
				begin
					if (cmd_lvl_reg && pin_r[wlm_pkg::WLM_PIN_LVL])
					begin
						state_r <= wlm_pkg::WLM_ENTRY;
						cnt_r   <= mod_cyc_r;
					end
				end
				wlm_pkg::WLM_ENTRY:
				begin
					if (cmd_lvl_reg && !pin_r[wlm_pkg::WLM_PIN_LVL])
					begin
						state_r <= wlm_pkg::WLM_EXIT;
						cnt_r   <= mod_cyc_r;
					end
					else if (cnt_r == 8'h00)
						state_r <= wlm_pkg::WLM_ACTIVE;
					else
						cnt_r <= cnt_r - 8'h01;
				end
				wlm_pkg::WLM_ACTIVE:
				begin
					if (cmd_lvl_reg && !pin_r[wlm_pkg::WLM_PIN_LVL])
					begin
						state_r <= wlm_pkg::WLM_EXIT;
						cnt_r   <= mod_cyc_r;
					end
				end
				wlm_pkg::WLM_EXIT:
				begin
					if (cnt_r == 8'h00)
						state_r <= wlm_pkg::WLM_NORMAL;
					else
						cnt_r <= cnt_r - 8'h01;
				end
				default:
					state_r <= wlm_pkg::WLM_NORMAL;
			endcase
		end
	end

	// output disable bit follows every mode set to the leveling register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			qoff_r <= 1'b0;
		else if (cmd_lvl_reg)
			qoff_r <= pin_r[wlm_pkg::WLM_PIN_QOFF];
	end

	// ----------------------------------------------------------------
	// command checking
	// ----------------------------------------------------------------
	// gap timer restarts on each mode set
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			gap_r <= 8'h00;
		else if (cmd_ms)
			gap_r <= gap_cyc_r;
		else if (gap_r != 8'h00)
			gap_r <= gap_r - 8'h01;
	end

	// flag commands that leveling or its exit timing forbids
	always_comb
	begin
		err_set = 2'h0;
		if (cmd_take)
		begin
			if ((state_r == wlm_pkg::WLM_ENTRY || state_r == wlm_pkg::WLM_ACTIVE) && !cmd_lvl_reg)
				err_set[wlm_pkg::WLM_ERR_ILLEGAL] = 1'b1;
			if (state_r == wlm_pkg::WLM_EXIT && !cmd_ms)
				err_set[wlm_pkg::WLM_ERR_ILLEGAL] = 1'b1;
		end
		if (cmd_ms && gap_r != 8'h00)
			err_set[wlm_pkg::WLM_ERR_GAP] = 1'b1;
	end

	// ----------------------------------------------------------------
	// termination
	// ----------------------------------------------------------------
	// the termination pin is ignored until the entry delay has run out
	assign term_ok  = state_r != wlm_pkg::WLM_ENTRY;
	assign term_eff = term_ok && pin_r[wlm_pkg::WLM_PIN_TERM];

	// in leveling only the strobe is terminated, data lines stay open
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dqs_term_en  <= 1'b0;
			dqs_term_nom <= 1'b0;
			dq_term_en   <= 1'b0;
		end
		else if (state_r == wlm_pkg::WLM_ENTRY || state_r == wlm_pkg::WLM_ACTIVE)
		begin
			dqs_term_nom <= term_eff;
			dqs_term_en  <= term_eff ? ctrl_r[wlm_pkg::WLM_CTRL_NOM]
			                         : ctrl_r[wlm_pkg::WLM_CTRL_PARK];
			dq_term_en   <= 1'b0;
		end
		else
		begin
			dqs_term_nom <= pin_r[wlm_pkg::WLM_PIN_TERM];
			dqs_term_en  <= pin_r[wlm_pkg::WLM_PIN_TERM] ? ctrl_r[wlm_pkg::WLM_CTRL_NOM]
			                                             : ctrl_r[wlm_pkg::WLM_CTRL_PARK];
			dq_term_en   <= pin_r[wlm_pkg::WLM_PIN_TERM] ? ctrl_r[wlm_pkg::WLM_CTRL_NOM]
			                                             : ctrl_r[wlm_pkg::WLM_CTRL_PARK];
		end
	end

	// ----------------------------------------------------------------
	// byte lanes
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			wlm_lane_if lif ();

			assign lif.dqs_pin = dqs_pin[g];
			assign lif.ck_lvl  = pin_r[wlm_pkg::WLM_PIN_CK];
			assign lif.active  = (state_r == wlm_pkg::WLM_ACTIVE) && lane_on[g];
			assign lane_fb[g]  = lif.fb[0];

			wlm_lane_fb u_fb (
				.core_clk (core_clk),
				.arst_n   (arst_n),
				.ln       (lif.lane)
			);

			// feedback byte of this lane only, off while undefined
			always_ff @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					dq_o[g*8 +: 8]  <= 8'h00;
					dq_oe[g*8 +: 8] <= 8'h00;
				end
				else
				begin
					dq_o[g*8 +: 8]  <= lif.fb;
					dq_oe[g*8 +: 8] <= {8{lif.active && !qoff_r}};
				end
			end
		end
	endgenerate

	// lane zero always levels, upper lanes only in wide mode
	assign lane_on = {{(LANES-1){ctrl_r[wlm_pkg::WLM_CTRL_WIDE]}}, 1'b1};

	// read strobes stay off for the whole leveling sequence
	assign dqs_oe    = '0;
	assign wl_active = state_r != wlm_pkg::WLM_NORMAL;

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;

	// software settings and mode update timing
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_r    <= wlm_pkg::WLM_CTRL_RST;
			mod_cyc_r <= wlm_pkg::WLM_MOD_CYC;
			gap_cyc_r <= wlm_pkg::WLM_MRD_CYC;
		end
		else if (wr_en)
		begin
			if (paddr == wlm_pkg::WLM_CTRL_OFS)
				ctrl_r <= pwdata[2:0];
			else if (paddr == wlm_pkg::WLM_MODCYC_OFS)
				mod_cyc_r <= pwdata[7:0];
			else if (paddr == wlm_pkg::WLM_GAPCYC_OFS)
				gap_cyc_r <= pwdata[7:0];
		end
	end

	// sticky error flags, a new event beats a clear
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			err_r <= 2'h0;
		else if (wr_en && paddr == wlm_pkg::WLM_ERR_OFS)
			err_r <= (err_r & ~pwdata[1:0]) | err_set;
		else
			err_r <= err_r | err_set;
	end

	// read decode, unmapped addresses answer with an error
	always_comb
	begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == wlm_pkg::WLM_CTRL_OFS)
			prdata[2:0] = ctrl_r;
		else if (paddr == wlm_pkg::WLM_STATUS_OFS)
		begin
			prdata[wlm_pkg::WLM_ST_ACTIVE] = wl_active;
			prdata[wlm_pkg::WLM_ST_TERMOK] = term_ok && wl_active;
			prdata[wlm_pkg::WLM_ST_UNDEF]  = state_r == wlm_pkg::WLM_ENTRY ||
			                                 state_r == wlm_pkg::WLM_EXIT;
			prdata[wlm_pkg::WLM_ST_QOFF]   = qoff_r;
			prdata[wlm_pkg::WLM_ST_FB +: LANES] = lane_fb;
			prdata[wlm_pkg::WLM_ST_STATE +: 2]  = state_r;
		end
		else if (paddr == wlm_pkg::WLM_ERR_OFS)
			prdata[1:0] = err_r;
		else if (paddr == wlm_pkg::WLM_MODCYC_OFS)
			prdata[7:0] = mod_cyc_r;
		else if (paddr == wlm_pkg::WLM_GAPCYC_OFS)
			prdata[7:0] = gap_cyc_r;
		else
			pslverr = psel && penable;
	end

endmodule

// file: src/wlm_pkg.sv
// Functional notes
// - mode set with leveling bit one enters leveling
// - mode set with leveling bit zero exits
// - termination pin switches only strobe termination
// - output disable bit: zero on, one off
// - nominal and parked settings work either buffer state
// - data pins undefined from entry onward
// - exit mode set may change other bits
// - termination pin honoured after mode update delay
// - strobe termination applied before strobe drive
// - rising strobe samples clock, level drives data
// - data bit feedback skew within window
// - no read strobes driven with feedback
// - feedback one means clock was high
// - data pins undefined until delay after exit
// - commands after update delay, mode sets after gap
// - each byte lane leveled and reported separately
package wlm_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  WLM_CTRL_OFS    = 8'h00;
	localparam logic [7:0]  WLM_STATUS_OFS  = 8'h04;
	localparam logic [7:0]  WLM_ERR_OFS     = 8'h08;
	localparam logic [7:0]  WLM_MODCYC_OFS  = 8'h0C;
	localparam logic [7:0]  WLM_GAPCYC_OFS  = 8'h10;

	// ctrl fields
	localparam int          WLM_CTRL_WIDE   = 0;
	localparam int          WLM_CTRL_NOM    = 1;
	localparam int          WLM_CTRL_PARK   = 2;
	localparam logic [2:0]  WLM_CTRL_RST    = 3'h7;

	// status fields
	localparam int          WLM_ST_ACTIVE   = 0;
	localparam int          WLM_ST_TERMOK   = 1;
	localparam int          WLM_ST_UNDEF    = 2;
	localparam int          WLM_ST_QOFF     = 3;
	localparam int          WLM_ST_FB       = 4;
	localparam int          WLM_ST_STATE    = 8;

	// error fields, write one to clear
	localparam int          WLM_ERR_ILLEGAL = 0;
	localparam int          WLM_ERR_GAP     = 1;

	// ----------------------------------------------------------------
	// command pin vector layout and mode register bits
	// ----------------------------------------------------------------
	localparam int          WLM_PIN_W       = 9;
	localparam int          WLM_PIN_CK      = 8;
	localparam int          WLM_PIN_TERM    = 7;
	localparam int          WLM_PIN_CS_N    = 6;
	localparam int          WLM_PIN_MS_N    = 5;
	localparam int          WLM_PIN_SEL     = 2;
	localparam int          WLM_PIN_QOFF    = 1;
	localparam int          WLM_PIN_LVL     = 0;
	localparam logic [8:0]  WLM_PIN_RST     = 9'h060;
	localparam logic [2:0]  WLM_MR_LEVEL    = 3'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          WLM_CLK_NS      = 40;
	localparam int          WLM_MOD_NS      = 120;
	localparam int          WLM_MRD_NS      = 80;
	localparam logic [7:0]  WLM_MOD_CYC     = 8'((WLM_MOD_NS + WLM_CLK_NS - 1) / WLM_CLK_NS);
	localparam logic [7:0]  WLM_MRD_CYC     = 8'((WLM_MRD_NS + WLM_CLK_NS - 1) / WLM_CLK_NS);

	typedef enum logic [1:0] {
		WLM_NORMAL,
		WLM_ENTRY,
		WLM_ACTIVE,
		WLM_EXIT
	} wlm_state_t;

endpackage

// file: src/wlm_lane_if.sv
`timescale 1ns/100ps
// carries one byte lane between the mode logic and its feedback unit
interface wlm_lane_if;
	logic        dqs_pin;
	logic        ck_lvl;
	logic        active;
	logic [7:0]  fb;

	modport lane (input dqs_pin, input ck_lvl, input active, output fb);
	modport ctrl (output dqs_pin, output ck_lvl, output active, input fb);
endinterface

// file: src/wlm_lane_fb.sv
`timescale 1ns/100ps
// per lane strobe capture of the clock level
module wlm_lane_fb (
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   arst_n,
	// lane link
	wlm_lane_if.lane    ln
);

	logic [2:0]  dqs_sync_r;
	logic        dqs_flt_r;
	logic        dqs_rise;

	// ----------------------------------------------------------------
	// strobe synchroniser and edge
	// ----------------------------------------------------------------
	// three stages, change accepted once stage two and three agree
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dqs_sync_r <= 3'h0;
			dqs_flt_r  <= 1'b0;
		end
		else
		begin
			dqs_sync_r <= {dqs_sync_r[1:0], ln.dqs_pin};
			if (dqs_sync_r[1] == dqs_sync_r[2])
				dqs_flt_r <= dqs_sync_r[2];
		end
	end

	assign dqs_rise = !dqs_flt_r && (dqs_sync_r[1] == dqs_sync_r[2]) && dqs_sync_r[2];

	// ----------------------------------------------------------------
	// feedback byte
	// ----------------------------------------------------------------
	// every bit of the lane changes on the same edge, so skew is nil
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ln.fb <= 8'h00;
		else if (!ln.active)
			ln.fb <= 8'h00;
		else if (dqs_rise)
			ln.fb <= {8{ln.ck_lvl}};
	end

endmodule

// file: dv/wlm_write_leveling_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checks of the leveling block
// ----------------------------------------------------------------
module wlm_write_leveling_properties #(
	parameter int LANES = 2
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               arst_n,
	// mode set address bit
	input  wire logic               output_disable_bit,
	// data and termination pins
	input  wire logic [LANES*8-1:0] dq_o,
	input  wire logic [LANES*8-1:0] dq_oe,
	input  wire logic [LANES-1:0]   dqs_oe,
	input  wire logic               dq_term_en,
	input  wire logic               wl_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	AST_NO_RD_STROBE: assert property (dqs_oe == '0)
		else $error("read strobe driven");
	AST_DQ_TERM_OFF: assert property (|dq_oe |-> !dq_term_en)
		else $error("data termination on while feedback driven");
	AST_DQ_REL_NORMAL: assert property (!wl_active |=> dq_oe == '0)
		else $error("data pins driven outside leveling");
	AST_LANE_UNIFORM: assert property (dq_o[7:0] == {8{dq_o[0]}}
		&& dq_o[LANES*8-1 -: 8] == {8{dq_o[LANES*8-8]}})
		else $error("lane feedback bits differ");
	AST_FB_ONLY_LEVEL: assert property (dq_o != '0 |-> wl_active)
		else $error("feedback outside leveling");
	AST_ENTRY_QUIET: assert property ($rose(wl_active) |-> dq_oe == '0 [*3])
		else $error("data pins driven during entry");
	AST_ENTRY_TERM: assert property ($rose(wl_active) |=> !dq_term_en [*3])
		else $error("data termination kept during entry");
	AST_EXIT_HOLD: assert property ($fell(|dq_oe) && wl_active |-> wl_active [*3])
		else $error("exit shorter than mode update delay");
	AST_OE_AFTER_ENTRY: assert property ($rose(wl_active) && !output_disable_bit
		|-> ##[3:300] (|dq_oe || !wl_active || output_disable_bit))
		else $error("feedback never enabled after entry");
endmodule

bind wlm_write_leveling wlm_write_leveling_properties #(.LANES(LANES)) u_props (
	.core_clk           (core_clk),
	.arst_n             (arst_n),
	.output_disable_bit (output_disable_bit),
	.dq_o               (dq_o),
	.dq_oe              (dq_oe),
	.dqs_oe             (dqs_oe),
	.dq_term_en         (dq_term_en),
	.wl_active          (wl_active)
);

// file: dv/wlm_ctl_model.sv
`timescale 1ns/100ps
// controller side: command pins and per lane strobes with adjustable delay
module wlm_ctl_model (
	// clocks
	input  wire logic  core_clk,
	input  wire logic  ck_pin,
	// command pins
	output logic       term_pin,
	output logic       cs_n,
	output logic       ms_n,
	output logic [2:0] mr_sel,
	output logic       q_off,
	output logic       lvl_en,
	// strobes
	output logic [1:0] dqs
);
	// idle: idle_select_command, one rank only, termination pin starts low
	initial
	begin
		term_pin = 1'b0;
		cs_n = 1'b1;
		ms_n = 1'b1;
		mr_sel = 3'h0;
		q_off = 1'b0;
		lvl_en = 1'b0;
		dqs = 2'h0;
	end

	// one command, address held around the select pulse, then a long pause
	task automatic cmd(input logic is_ms, input logic [2:0] r, input logic q, input logic l);
		@(posedge core_clk);
		ms_n <= !is_ms;
		mr_sel <= r;
		q_off <= q;
		lvl_en <= l;
		repeat (5) @(posedge core_clk);
		cs_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		cs_n <= 1'b1;
		repeat (12) @(posedge core_clk);
	endtask

	// single strobe edge pair per lane, delay counted from a clock fall
	task automatic pulse(input int d0, input int d1);
		@(negedge ck_pin);
		for (int i = 0; i < 20; i++)
		begin
			@(posedge core_clk);
			dqs[0] <= (i >= d0 && i < d0 + 3);
			dqs[1] <= (i >= d1 && i < d1 + 3);
		end
	endtask
endmodule

// file: dv/sdram_write_leveling_mode_test.sv
`timescale 1ns/100ps
module sdram_write_leveling_mode_test;
	typedef struct {logic [32:0] val; logic [32:0] msk;} wlm_note_t;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	localparam logic [32:0] ST  = 33'h1_0000_0332;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, ck_pin;
	logic        term_pin, cs_n, ms_n, q_off, lvl_en, dqs_term_en, dqs_term_nom;
	logic        dq_term_en, wl_active;
	logic [2:0]  mr_sel;
	logic [1:0]  dqs, dqs_oe, b;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] dq_o, dq_oe;
	int          fail_count, cmp_count, seed;
	wlm_note_t   notes[$];
	wlm_note_t   note;

	wlm_write_leveling #(.LANES(2)) u_dut (
		.core_clk                (core_clk),
		.arst_n                  (arst_n),
		.paddr                   (paddr),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.ck_pin                  (ck_pin),
		.termination_control_pin (term_pin),
		.cs_n_pin                (cs_n),
		.ms_n_pin                (ms_n),
		.mr_sel_pin              (mr_sel),
		.output_disable_bit      (q_off),
		.leveling_enable_bit     (lvl_en),
		.dqs_pin                 (dqs),
		.dq_o                    (dq_o),
		.dq_oe                   (dq_oe),
		.dqs_oe                  (dqs_oe),
		.dqs_term_en             (dqs_term_en),
		.dqs_term_nom            (dqs_term_nom),
		.dq_term_en              (dq_term_en),
		.wl_active               (wl_active)
	);

	wlm_ctl_model u_ctl (
		.core_clk (core_clk),
		.ck_pin   (ck_pin),
		.term_pin (term_pin),
		.cs_n     (cs_n),
		.ms_n     (ms_n),
		.mr_sel   (mr_sel),
		.q_off    (q_off),
		.lvl_en   (lvl_en),
		.dqs      (dqs)
	);

	// core clock and free running memory clock of unrelated phase
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		ck_pin = 1'b0;
		#13;
		forever #160 ck_pin = ~ck_pin;
	end

	task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		// a read whose answer never came counts against the run
		fail_count += notes.size();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// apb transfer, request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
		notes.push_back('{v & m, m});
		apb(1'b0, a, 32'h0);
	endtask

	// termination for both settings and both pin levels
	task automatic term_sweep(input logic lvl);
		logic [2:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = i[1] ? 3'h5 : 3'h3;
			apb(1'b1, wlm_pkg::WLM_CTRL_OFS, {29'h0, c});
			u_ctl.term_pin <= i[0];
			repeat (8) @(posedge core_clk);
			chk("dqs term", {32'h0, dqs_term_en}, {32'h0, i[0] ? c[1] : c[2]});
			chk("dqs nom", {32'h0, dqs_term_nom}, {32'h0, i[0]});
			chk("dq term", {32'h0, dq_term_en}, {32'h0, !lvl && (i[0] ? c[1] : c[2])});
		end
	endtask

	// read monitor: oldest note against what the bus returns
	always @(posedge core_clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
		begin
			note = notes.pop_front();
			chk("apb read", {pslverr, prdata} & note.msk, note.val);
		end
	end

	initial
	begin
		#400000;
		fail_count++;
		final_report();
	end

	initial
	begin
		seed = 32'h686A0D56;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(wlm_pkg::WLM_MODCYC_OFS, {25'h0, wlm_pkg::WLM_MOD_CYC}, ALL);
		rd(wlm_pkg::WLM_STATUS_OFS, 33'h0, ST);
		rd(8'h14 + 8'($random(seed) & 8'h3C), 33'h1_0000_0000, ALL);
		term_sweep(1'b0);
		u_ctl.cmd(1'b1, wlm_pkg::WLM_MR_LEVEL, 1'b0, 1'b1);
		repeat (10) @(posedge core_clk);
		rd(wlm_pkg::WLM_STATUS_OFS, 33'h202, ST);
		term_sweep(1'b1);
		for (int n = 0; n < 4; n++)
		begin
			b = 2'($random(seed));
			u_ctl.pulse(b[0] ? 6 : 2, b[1] ? 6 : 2);
			chk("feedback", {17'h0, dq_o}, {17'h0, {8{b[1]}}, {8{b[0]}}});
			rd(wlm_pkg::WLM_STATUS_OFS, {23'h0, 2'h2, 2'h0, b, 4'h2}, ST);
		end
		u_ctl.cmd(1'b1, wlm_pkg::WLM_MR_LEVEL, 1'b1, 1'b1);
		chk("dq enable", {17'h0, dq_oe}, 33'h0);
		u_ctl.cmd(1'b1, wlm_pkg::WLM_MR_LEVEL, 1'b0, 1'b1);
		chk("dq enable", {17'h0, dq_oe}, 33'hFFFF);
		u_ctl.cmd(1'b0, 3'h0, 1'b0, 1'b1);
		rd(wlm_pkg::WLM_ERR_OFS, 33'h1, ALL);
		apb(1'b1, wlm_pkg::WLM_ERR_OFS, 32'h3);
		rd(wlm_pkg::WLM_ERR_OFS, 33'h0, ALL);
		u_ctl.term_pin <= 1'b0;
		repeat (8) @(posedge core_clk);
		u_ctl.cmd(1'b1, wlm_pkg::WLM_MR_LEVEL, 1'b1, 1'b0);
		repeat (20) @(posedge core_clk);
		rd(wlm_pkg::WLM_STATUS_OFS, 33'h8, 33'h1_0000_0308);
		chk("dq enable", {17'h0, dq_oe}, 33'h0);
		apb(1'b1, wlm_pkg::WLM_GAPCYC_OFS, 32'h40);
		u_ctl.cmd(1'b1, 3'h2, 1'b0, 1'b0);
		u_ctl.cmd(1'b1, 3'h2, 1'b0, 1'b0);
		rd(wlm_pkg::WLM_ERR_OFS, 33'h2, ALL);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(wlm_pkg::WLM_GAPCYC_OFS, {25'h0, wlm_pkg::WLM_MRD_CYC}, ALL);
		rd(wlm_pkg::WLM_CTRL_OFS, 33'h7, ALL);
		final_report();
	end
endmodule
